// file: freeze_pad_defines.svh
`ifndef FREEZE_PAD_DEFINES_SVH
`define FREEZE_PAD_DEFINES_SVH

// ----------------------------------------
// Reset values
// ----------------------------------------
`define HELD_VALUE_RESET 1'b0
`define FROZEN_RESET 1'b0
`define CORE_IN_RESET 1'b1

// ----------------------------------------
// Default widths
// ----------------------------------------
`define PIN_COUNT_DEFAULT 8

`endif

// file: freeze_pad_pkg.sv
package freeze_pad_pkg;
  // Pad behaviour: normal while running, else the mode used while frozen
  typedef enum logic [1:0] {
    PAD_NORMAL,
    PAD_TRISTATE,
    PAD_WEAK_PULL,
    PAD_WEAK_HOLD
  } pad_mode_e;
  // Freeze sequencing state
  typedef enum logic [1:0] {
    ST_RUN,
    ST_FROZEN
  } freeze_state_e;
endpackage

// file: freeze_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
`include "freeze_pad_defines.svh"

// ----------------------------------------
// One pad: combinational decode of freeze behaviour
// ----------------------------------------
module freeze_pin_cell
  import freeze_pad_pkg::*;
(
  input wire logic frozen,
  input wire logic hold_en,
  input wire logic pull_en,
  input wire logic pull_up,
  input wire logic is_output,
  input wire logic is_bidir,
  input wire logic core_oe,
  input wire logic held_value,
  output logic out_mode_weak,
  output logic [1:0] pad_mode
);
  logic drives;

  // Bidir follows input table when its enable is low
  always_comb begin
    drives = is_bidir ? core_oe : is_output; // RULE_11
    out_mode_weak = drives & hold_en;
    if (!frozen) begin
      pad_mode = PAD_NORMAL;
    end else if (drives && hold_en) begin
      pad_mode = PAD_WEAK_HOLD; // RULE_02 RULE_10
    end else if (pull_en) begin
      pad_mode = PAD_WEAK_PULL; // RULE_05 RULE_07
    end else begin
      pad_mode = PAD_TRISTATE; // RULE_06 RULE_07
    end
  end
endmodule
`default_nettype wire

// file: freeze_mode_pad_state.sv
`timescale 1ns/1ps
`default_nettype none
`include "freeze_pad_defines.svh"

// Summary of operation
// (RULE_01) Each pin picks hold, weak pull or tristate for freeze independently.
// (RULE_02) Held output keeps last registered value using a weak pull that way.
// (RULE_03) Held input keeps last pad value sampled before freeze entry.
// (RULE_04) Pad activity during freeze never changes a held core value.
// (RULE_05) Pull without hold shows the configured pull throughout freeze.
// (RULE_06) No hold and no pull tristates the pad; core input reads high.
// (RULE_07) Input pad shows pull if enabled, else tristate, regardless of hold.
// (RULE_08) Held input drives core with pin value at freeze entry.
// (RULE_09) Unheld input drives core high for the whole freeze.
// (RULE_10) Held output pulls weakly to held state; else pull or tristate.
// (RULE_11) Bidir acts as input when enable low, output when high.
// (RULE_12) Bidir output with hold gives core input the held state too.
// (RULE_13) Freeze request must be actively driven, never weakly pulled.
// (RULE_14) Per-pin settings are static and unchanged during freeze.
module freeze_mode_pad_state
  import freeze_pad_pkg::*;
#(
  parameter int PIN_COUNT = `PIN_COUNT_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic freeze_request_pin,
  input wire logic [PIN_COUNT-1:0] hold_en,
  input wire logic [PIN_COUNT-1:0] pull_en,
  input wire logic [PIN_COUNT-1:0] pull_up,
  input wire logic [PIN_COUNT-1:0] is_output,
  input wire logic [PIN_COUNT-1:0] is_bidir,
  input wire logic [PIN_COUNT-1:0] core_out,
  input wire logic [PIN_COUNT-1:0] core_oe,
  input wire logic [PIN_COUNT-1:0] pad_in,
  output logic [PIN_COUNT-1:0] core_in,
  output logic [PIN_COUNT-1:0] pad_out,
  output logic [PIN_COUNT-1:0] pad_oe,
  output logic [PIN_COUNT-1:0] pad_pull_en,
  output logic [PIN_COUNT-1:0] pad_pull_up,
  output logic frozen
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (PIN_COUNT < 1 || PIN_COUNT > 1024) begin : g_bad_count
    $error("PIN_COUNT out of range");
  end

  typedef struct packed {
    freeze_state_e state;
    logic frozen;
    logic [PIN_COUNT-1:0] held;
    logic [PIN_COUNT-1:0] core_in;
    logic [PIN_COUNT-1:0] pad_out;
    logic [PIN_COUNT-1:0] pad_oe;
    logic [PIN_COUNT-1:0] pull_en;
    logic [PIN_COUNT-1:0] pull_up;
  } state_s;

  state_s cur;
  state_s next_cur;
  logic [PIN_COUNT-1:0] weak_out;
  logic [1:0] mode [PIN_COUNT];
  logic entering;
  logic [PIN_COUNT-1:0] drives;

  // A bidir pin obeys its enable; its output flag is then ignored
  function automatic logic [PIN_COUNT-1:0] drive_mask(
    input logic [PIN_COUNT-1:0] out_pin,
    input logic [PIN_COUNT-1:0] bidir,
    input logic [PIN_COUNT-1:0] oe
  );
    return (bidir & oe) | (~bidir & out_pin);
  endfunction

  // Pads the core drives right now
  assign drives = drive_mask(is_output, is_bidir, core_oe); // RULE_11

  // ----------------------------------------
  // Per-pin decode
  // ----------------------------------------
  // Settings are assumed static, so the decode needs no capture
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin // RULE_01 RULE_14
    freeze_pin_cell u_cell (
      .frozen(cur.state == ST_FROZEN),
      .hold_en(hold_en[i]),
      .pull_en(pull_en[i]),
      .pull_up(pull_up[i]),
      .is_output(is_output[i]),
      .is_bidir(is_bidir[i]),
      .core_oe(core_oe[i]),
      .held_value(cur.held[i]),
      .out_mode_weak(weak_out[i]),
      .pad_mode(mode[i])
    );
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Request is treated as a driven level; no filter for a floating pin
  always_comb begin
    next_cur = cur;
    entering = (cur.state == ST_RUN) && freeze_request_pin; // RULE_13
    case (cur.state)
      ST_RUN: begin
        if (freeze_request_pin) begin
          next_cur.state = ST_FROZEN;
        end
      end
      ST_FROZEN: begin
        if (!freeze_request_pin) begin
          next_cur.state = ST_RUN;
        end
      end
      default: next_cur.state = ST_RUN;
    endcase
    next_cur.frozen = (next_cur.state == ST_FROZEN);
    for (int i = 0; i < PIN_COUNT; i++) begin
      // Output pins remember driven value, inputs the pad value
      if (cur.state == ST_RUN) begin
        if (drives[i]) begin
          next_cur.held[i] = core_out[i]; // RULE_02
        end else begin
          next_cur.held[i] = pad_in[i]; // RULE_03 RULE_08
        end
      end
      // Frozen: held never updates from pad activity
      if (next_cur.state == ST_RUN) begin
        next_cur.core_in[i] = pad_in[i];
        next_cur.pad_out[i] = core_out[i];
        next_cur.pad_oe[i] = drives[i]; // RULE_11
        next_cur.pull_en[i] = pull_en[i];
        next_cur.pull_up[i] = pull_up[i];
      end else begin
        next_cur.pad_out[i] = 1'b0;
        next_cur.pad_oe[i] = 1'b0;
        if (entering) begin
          // First frozen cycle uses the freshly captured value
          next_cur.core_in[i] = hold_en[i] ? next_cur.held[i] : 1'b1; // RULE_08 RULE_09
          if (drives[i] && hold_en[i]) begin
            next_cur.pull_en[i] = 1'b1;
            next_cur.pull_up[i] = next_cur.held[i]; // RULE_10 RULE_12
          end else begin
            next_cur.pull_en[i] = pull_en[i];
            next_cur.pull_up[i] = pull_up[i];
          end
        end else begin
          next_cur.core_in[i] = hold_en[i] ? cur.held[i] : 1'b1; // RULE_04 RULE_06 RULE_09
          case (mode[i])
            PAD_WEAK_HOLD: begin
              next_cur.pull_en[i] = 1'b1;
              next_cur.pull_up[i] = cur.held[i]; // RULE_02 RULE_12
            end
            PAD_WEAK_PULL: begin
              next_cur.pull_en[i] = 1'b1;
              next_cur.pull_up[i] = pull_up[i]; // RULE_05 RULE_07
            end
            default: begin
              next_cur.pull_en[i] = 1'b0;
              next_cur.pull_up[i] = 1'b0; // RULE_06 RULE_07
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cur.state <= ST_RUN;
      cur.frozen <= `FROZEN_RESET;
      cur.held <= {PIN_COUNT{`HELD_VALUE_RESET}};
      cur.core_in <= {PIN_COUNT{`CORE_IN_RESET}};
      cur.pad_out <= '0;
      cur.pad_oe <= '0;
      cur.pull_en <= '0;
      cur.pull_up <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from flip-flops
  assign core_in = cur.core_in;
  assign pad_out = cur.pad_out;
  assign pad_oe = cur.pad_oe;
  assign pad_pull_en = cur.pull_en;
  assign pad_pull_up = cur.pull_up;
  assign frozen = cur.frozen;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_frozen_no_drive: assert property (frozen |-> pad_oe == '0) // RULE_06
    else $error("pad driven while frozen");
  a_held_core_stable: assert property (frozen && $past(frozen) |-> $stable(core_in)) // RULE_04
    else $error("core input moved during freeze");
  a_unheld_core_high: assert property (frozen |-> (core_in | hold_en) == '1) // RULE_09
    else $error("unheld core input not high");
  a_entry_latency: assert property ($rose(freeze_request_pin) |=> frozen) // RULE_13
    else $error("freeze not entered in one cycle");
  a_exit_latency: assert property (frozen && !freeze_request_pin |=> !frozen) // RULE_13
    else $error("freeze not left in one cycle");
  a_hold_pull_on: assert property (frozen && $past(frozen) |-> (pad_pull_en | ~(weak_out | pull_en)) == '1) // RULE_10
    else $error("weak pull missing in freeze");
  a_hold_core_value: assert property (frozen && $past(frozen) |-> ((core_in ^ cur.held) & hold_en) == '0) // RULE_08
    else $error("held core value wrong");
  a_hold_pull_dir: assert property (frozen && $past(frozen) |-> ((pad_pull_up ^ cur.held) & weak_out) == '0) // RULE_12
    else $error("hold pull direction wrong");
  // Pass-through is one register deep, also on the exit edge
  a_run_pad_drive: assert property (!frozen && $past(reset_n) |-> // RULE_11
    pad_oe == $past(drives) && pad_out == $past(core_out))
    else $error("pad drive not following core");
  a_run_core_pass: assert property (!frozen && $past(reset_n) |-> // RULE_03
    core_in == $past(pad_in))
    else $error("core input not following pad");

  c_enter: cover property ($rose(frozen));
  c_exit: cover property ($fell(frozen));
  c_long_freeze: cover property (frozen [*4]);
  c_hold_bidir: cover property (frozen && (weak_out & is_bidir) != '0);
endmodule
`default_nettype wire

// file: pad_board.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Board side of the pads
// ----------------------------------------
module pad_board (
  input wire logic clk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pull_en,
  input wire logic [7:0] pull_up,
  input wire logic [7:0] drive_en,
  input wire logic [7:0] drive_val,
  output logic [7:0] pad_in
);
  logic [7:0] noise = 8'h5a;
  // Floating pad flips each cycle so a stale level never looks valid
  always @(posedge clk) noise <= ~noise;
  // Chip drive wins, then board drive, then weak pull
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (drive_en[i]) pad_in[i] = drive_val[i];
      else if (pull_en[i]) pad_in[i] = pull_up[i];
      else pad_in[i] = noise[i];
    end
  end
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Freeze pad bench
// ----------------------------------------
module tb_top import freeze_pad_pkg::*;;
  logic clk, reset_n, req, frz;
  logic [7:0] hold, pe, pu, iso, isb, cout, coe, pin, drv_en, drv, ci, po, poe, ppe, ppu;
  logic [40:0] exp_q[$], msk_q[$], last_e, last_m;
  logic [7:0] ov, run_ci;
  int num_errors = 0, cmp_count = 0, cycles = 0;

  freeze_mode_pad_state #(.PIN_COUNT(8)) i_dut (.clk(clk), .reset_n(reset_n),
    .freeze_request_pin(req), .hold_en(hold), .pull_en(pe), .pull_up(pu), .is_output(iso),
    .is_bidir(isb), .core_out(cout), .core_oe(coe), .pad_in(pin), .core_in(ci),
    .pad_out(po), .pad_oe(poe), .pad_pull_en(ppe), .pad_pull_up(ppu), .frozen(frz));
  pad_board i_board (.clk(clk), .pad_out(po), .pad_oe(poe), .pull_en(ppe), .pull_up(ppu),
    .drive_en(drv_en), .drive_val(drv), .pad_in(pin));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [40:0] seen, input logic [40:0] want);
    cmp_count++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Expected frozen image, taken from what the entry edge will sample
  task automatic note();
    logic [7:0] eci, epe, epu, mci, mpu;
    logic o;
    for (int i = 0; i < 8; i++) begin
      o = isb[i] ? coe[i] : iso[i];
      epe[i] = (o & hold[i]) | pe[i];
      epu[i] = (o & hold[i]) ? cout[i] : pu[i];
      mpu[i] = ~epe[i];
      eci[i] = hold[i] ? (o ? cout[i] : drv[i]) : 1'b1;
      mci[i] = o & ~(isb[i] & hold[i]);
    end
    last_m = {1'b0, mci, 8'h00, mpu, 16'h0000};
    last_e = {1'b1, eci, epe, epu, 16'h0000} | last_m;
    exp_q.push_back(last_e);
    msk_q.push_back(last_m);
  endtask

  // Watcher: compare once the freeze has taken effect
  always @(negedge clk) begin
    if (frz === 1'b1 && exp_q.size() > 0) begin
      check({frz, ci, ppe, ppu, poe, po} | msk_q.pop_front(), exp_q.pop_front());
    end
  end

  // Hang guard sized well above 24 freeze rounds
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    reset_n = 1'b0;
    req = 1'b0;
    {hold, pe, pu, iso, isb, cout, coe, drv} = 64'h0;
    drv_en = 8'hff;
    void'($urandom(32'h67454f0c));
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    check({16'h0000, frz, ci, poe, po}, {16'h0000, 1'b0, 8'hff, 16'h0000});
    for (int n = 0; n < 24; n++) begin
      @(negedge clk);
      // Config only moves outside freeze
      {hold, pe, pu, iso, isb, cout, coe, drv} = {$urandom(), $urandom()};
      drv_en = 8'hff;
      ov = (isb & coe) | (~isb & iso);
      run_ci = (ov & cout) | (~ov & drv);
      // Two edges: pad enables settle first, then the pads they shape are sampled
      repeat (2) @(negedge clk);
      check({frz, ci, ppe, ppu, poe, po}, {1'b0, run_ci, pe, pu, ov, cout});
      note();
      req = 1'b1;
      repeat (2) @(negedge clk);
      // Board wiggles held pads; core side must not move
      {drv_en, drv} = 16'($urandom());
      repeat (3) @(negedge clk);
      exp_q.push_back(last_e);
      msk_q.push_back(last_m);
      @(negedge clk);
      req = 1'b0;
      repeat (2) @(negedge clk);
      check({8'h00, frz, ppe, ppu, poe, po}, {8'h00, 1'b0, pe, pu, ov, cout});
    end
    stop_test();
  end
endmodule
`default_nettype wire
